// >>> core/vak_cfg.svh
`ifndef VAK_CFG_SVH
`define VAK_CFG_SVH
// Instruction field positions.
`define VAK_F6_HI 31
`define VAK_F6_LO 26
`define VAK_VM_BIT 25
`define VAK_KSRC_HI 24
`define VAK_KSRC_LO 20
`define VAK_IMM_HI 19
`define VAK_IMM_LO 15
`define VAK_F3_HI 14
`define VAK_F3_LO 12
`define VAK_DEST_HI 11
`define VAK_DEST_LO 7
`define VAK_OPC_HI 6
// Field codes.
`define VAK_OPC_VE 7'h77
`define VAK_F3_MVV 3'h2
`define VAK_F6_RVV 6'h28
`define VAK_F6_RVS 6'h29
`define VAK_F6_K128 6'h22
`define VAK_F6_K256 6'h2A
`define VAK_MIN_FINAL 5'h03
`define VAK_MIN_MID 5'h02
`define VAK_SEW_32 3'h2
// Group width in bits and log2 of elements per group.
`define VAK_GRP_BITS 16'h0080
`define VAK_GRP_LOG 2
// Round limits.
`define VAK_R128_MAX 4'hA
`define VAK_R256_MIN 4'h2
`define VAK_R256_MAX 4'hE
// Field constants of the cipher.
`define VAK_POLY 8'h1B
`define VAK_AFFINE 8'h63
`endif

// >>> core/vak_pkg.sv
package vak_pkg;
    // Operation latched at issue.
    typedef enum logic [1:0] {
        VAK_FINAL,
        VAK_MID,
        VAK_KEY128,
        VAK_KEY256
    } vak_op_e;
    // Sequencer states.
    typedef enum logic [1:0] {
        VAK_IDLE,
        VAK_RUN,
        VAK_DRAIN
    } vak_state_e;
    // One 128-bit element group.
    typedef logic [127:0] vak_block_t;
endpackage

// >>> core/vak_core.sv
// Function
// - Decode final-round encrypt, vv and vs
// - Decode middle-round encrypt, vv and vs
// - Element width not 32 is reserved
// - Scalar form: dest overlapping key is reserved
// - Final: SubBytes, ShiftRows, add key
// - Middle: SubBytes, ShiftRows, MixColumns, add key
// - Key group i, or group 0 scalar
// - Latency independent of data values
// - Too short register group raises illegal
// - Process groups start/4 to length/4 minus one
// - Decode 128-bit key step
// - 128 round from imm[3:0], bit4 ignored
// - 128 out-of-range rounds flip bit 3
// - 128 key words: rot, sub, rcon chain
// - Decode 256-bit key step
// - 256 round from imm[3:0], bit4 ignored
// - 256 out-of-range rounds flip bit 3
// - 256 word zero odd/even round forms
// - 256 chain over previous key, overwrite dest
//
`include "vak_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vak_core #(
    parameter int VLW = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [31:0] instr,
    input wire logic [2:0] sew,
    input wire logic [15:0] groupBits,
    input wire logic [3:0] groupRegs,
    input wire logic [VLW-1:0] vectorLength,
    input wire logic [VLW-1:0] startIndex,
    input wire vak_pkg::vak_block_t stateData,
    input wire vak_pkg::vak_block_t keyData,
    output logic busy,
    output logic rdValid,
    output logic [VLW-3:0] rdGroup,
    output logic [VLW-3:0] keyGroup,
    output logic wrEn,
    output logic [VLW-3:0] wrGroup,
    output vak_pkg::vak_block_t wrData,
    output logic done,
    output logic illegal
);
    import vak_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Cipher primitives.

    // Multiply in GF(2^8); a fixed loop keeps timing free of data.
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] aa;
        p = 8'h00;
        aa = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ aa;
            aa = {aa[6:0], 1'b0} ^ (aa[7] ? `VAK_POLY : 8'h00);
        end
        return p;
    endfunction

    // Forward S-box: inverse as x^254, then the affine map. Computing it
    // costs area but avoids a table lookup whose timing could leak.
    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] a;
        logic [7:0] r;
        a = x;
        r = 8'h01;
        for (int i = 1; i < 8; i++) begin
            a = gmul(a, a);
            r = gmul(r, a);
        end
        return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
            ^ {r[3:0], r[7:4]} ^ `VAK_AFFINE;
    endfunction

    // Substitute every byte of one word.
    function automatic logic [31:0] subWord(input logic [31:0] w);
        logic [31:0] o;
        for (int i = 0; i < 4; i++) o[8*i+:8] = sbox(w[8*i+:8]);
        return o;
    endfunction

    // Rotate one byte position, low byte moves to the top.
    function automatic logic [31:0] rotWord(input logic [31:0] w);
        return {w[7:0], w[31:8]};
    endfunction

    // Round constant for index 0 to 9 by repeated doubling.
    function automatic logic [31:0] rcon(input logic [3:0] idx);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(idx)) r = gmul(r, 8'h02);
        end
        return {24'h00_0000, r};
    endfunction

    // Byte k of the state sits at row k mod 4, column k div 4.
    function automatic vak_block_t shiftRows(input vak_block_t s);
        vak_block_t o;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                o[8*(4*c+r)+:8] = s[8*(4*((c+r)%4)+r)+:8];
            end
        end
        return o;
    endfunction

    // Column mix with the fixed 2,3,1,1 matrix.
    function automatic vak_block_t mixColumns(input vak_block_t s);
        vak_block_t o;
        logic [7:0] a [4];
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) a[r] = s[8*(4*c+r)+:8];
            for (int r = 0; r < 4; r++) begin
                o[8*(4*c+r)+:8] = gmul(a[r], 8'h02) ^ gmul(a[(r+1)%4], 8'h03)
                    ^ a[(r+2)%4] ^ a[(r+3)%4];
            end
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Issue-time decode of the incoming instruction.

    logic [5:0] f6; // Major function code.
    logic [4:0] minor; // Minor field or immediate.
    logic [4:0] destNum; // Destination register number.
    logic [4:0] keySrcNum; // Key source register number.
    logic baseOk; // Opcode, funct3 and vm all match.
    logic isFinal;
    logic isMid;
    logic isK128;
    logic isK256;
    logic overlap; // Scalar form dest group covers the key register.
    logic bad; // Any reason to refuse the instruction.
    vak_op_e opNext;

    assign f6 = instr[`VAK_F6_HI:`VAK_F6_LO];
    assign minor = instr[`VAK_IMM_HI:`VAK_IMM_LO];
    assign destNum = instr[`VAK_DEST_HI:`VAK_DEST_LO];
    assign keySrcNum = instr[`VAK_KSRC_HI:`VAK_KSRC_LO];

    // Decode; anything not one of the four ops is refused here.
    always_comb begin
        baseOk = instr[`VAK_OPC_HI:0] == `VAK_OPC_VE && instr[`VAK_VM_BIT]
            && instr[`VAK_F3_HI:`VAK_F3_LO] == `VAK_F3_MVV;
        isFinal = baseOk && (f6 == `VAK_F6_RVV || f6 == `VAK_F6_RVS)
            && minor == `VAK_MIN_FINAL;
        isMid = baseOk && (f6 == `VAK_F6_RVV || f6 == `VAK_F6_RVS)
            && minor == `VAK_MIN_MID;
        isK128 = baseOk && f6 == `VAK_F6_K128;
        isK256 = baseOk && f6 == `VAK_F6_K256;
        overlap = f6 == `VAK_F6_RVS && keySrcNum >= destNum
            && {1'b0, keySrcNum} < {1'b0, destNum} + {2'b00, groupRegs};
        // Reserved encodings are refused rather than given a meaning.
        bad = !(isFinal || isMid || isK128 || isK256) || sew != `VAK_SEW_32
            || ((isFinal || isMid) && overlap)
            || groupBits < `VAK_GRP_BITS;
        if (isFinal) opNext = VAK_FINAL;
        else if (isMid) opNext = VAK_MID;
        else if (isK128) opNext = VAK_KEY128;
        else opNext = VAK_KEY256;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer. One group is read per cycle, so latency depends only on
    // the group range, never on state, key or immediate values.

    localparam int GW = VLW - `VAK_GRP_LOG;
    vak_state_e state_reg;
    vak_op_e op_reg; // Operation being run.
    logic vv_reg; // Vector-vector form: key follows the group.
    logic [3:0] round_reg; // Raw round field, bit 4 dropped.
    logic [GW-1:0] idx_reg; // Next group to read.
    logic [GW-1:0] first_reg; // First group of the body.
    logic [GW-1:0] end_reg; // One past the last group.
    logic dataValid_reg; // Read data present this cycle.
    logic [GW-1:0] dataGroup_reg; // Group index of the read data.
    logic [GW-1:0] startGrp;
    logic [GW-1:0] endGrp;

    assign startGrp = startIndex[VLW-1:`VAK_GRP_LOG];
    assign endGrp = vectorLength[VLW-1:`VAK_GRP_LOG];

    // Main sequence: issue, stream reads, drain, then report.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= VAK_IDLE;
            idx_reg <= '0;
            rdValid <= 1'b0;
            rdGroup <= '0;
            keyGroup <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
            busy <= 1'b0;
        end else begin
            done <= 1'b0;
            illegal <= 1'b0;
            case (state_reg)
                VAK_IDLE: begin
                    if (start && bad) begin
                        illegal <= 1'b1;
                    end else if (start && startGrp >= endGrp) begin
                        done <= 1'b1; // Empty body, nothing written.
                    end else if (start) begin
                        busy <= 1'b1;
                        rdValid <= 1'b1;
                        rdGroup <= startGrp;
                        keyGroup <= (f6 == `VAK_F6_RVS) ? '0 : startGrp;
                        idx_reg <= startGrp + 1'b1;
                        state_reg <= VAK_RUN;
                    end
                end
                VAK_RUN: begin
                    if (idx_reg == end_reg) begin
                        rdValid <= 1'b0;
                        state_reg <= VAK_DRAIN;
                    end else begin
                        rdGroup <= idx_reg;
                        keyGroup <= vv_reg ? idx_reg : '0;
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                VAK_DRAIN: begin
                    // Wait until the last result has been written out.
                    if (!dataValid_reg && !wrEn) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_reg <= VAK_IDLE;
                    end
                end
                default: state_reg <= VAK_IDLE;
            endcase
        end
    end

    // Latch the operation and its range at issue.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            op_reg <= VAK_FINAL;
            vv_reg <= 1'b0;
            round_reg <= '0;
            first_reg <= '0;
            end_reg <= '0;
        end else if (state_reg == VAK_IDLE && start) begin
            op_reg <= opNext;
            vv_reg <= f6 != `VAK_F6_RVS;
            round_reg <= minor[3:0];
            first_reg <= startGrp;
            end_reg <= endGrp;
        end
    end

    // Data follows the read one cycle later; track it.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dataValid_reg <= 1'b0;
            dataGroup_reg <= '0;
        end else begin
            dataValid_reg <= rdValid;
            dataGroup_reg <= rdGroup;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath for one group.

    logic [3:0] roundEff; // Round after folding out-of-range values.
    logic [31:0] kw [4]; // Key source words.
    logic [31:0] pw [4]; // Destination words (previous key).
    logic [31:0] nw [4]; // New key words.
    vak_block_t sr; // SubBytes then ShiftRows.
    vak_block_t result;

    // Fold the round number into range by flipping bit 3.
    always_comb begin
        roundEff = round_reg;
        if (op_reg == VAK_KEY128) begin
            if (round_reg > `VAK_R128_MAX || round_reg == 4'h0) begin
                roundEff[3] = ~round_reg[3];
            end
        end else if (round_reg < `VAK_R256_MIN || round_reg > `VAK_R256_MAX) begin
            roundEff[3] = ~round_reg[3];
        end
    end

    // Every operation runs the full logic cone each cycle.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sr[32*i+:32] = subWord(stateData[32*i+:32]);
            kw[i] = keyData[32*i+:32];
            pw[i] = stateData[32*i+:32];
        end
        sr = shiftRows(sr);
        nw[0] = '0;
        if (op_reg == VAK_KEY128) begin
            nw[0] = subWord(rotWord(kw[3])) ^ rcon(roundEff - 4'h1) ^ kw[0];
        end else if (roundEff[0]) begin
            nw[0] = subWord(kw[3]) ^ pw[0];
        end else begin
            nw[0] = subWord(rotWord(kw[3])) ^ rcon((roundEff >> 1) - 4'h1) ^ pw[0];
        end
        for (int n = 1; n < 4; n++) begin
            nw[n] = nw[n-1] ^ ((op_reg == VAK_KEY128) ? kw[n] : pw[n]);
        end
        case (op_reg)
            VAK_FINAL: result = sr ^ keyData;
            VAK_MID: result = mixColumns(sr) ^ keyData;
            default: result = {nw[3], nw[2], nw[1], nw[0]};
        endcase
    end

    // Write the result back to the group it was read from.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wrEn <= 1'b0;
            wrGroup <= '0;
            wrData <= '0;
        end else begin
            wrEn <= dataValid_reg;
            wrGroup <= dataGroup_reg;
            wrData <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    shortGroup_a: assert property (
        state_reg == VAK_IDLE && start && groupBits < `VAK_GRP_BITS
        |=> illegal && !rdValid && !done)
        else $error("short register group was not refused");

    sewReserved_a: assert property (
        state_reg == VAK_IDLE && start && sew != `VAK_SEW_32 |=> illegal)
        else $error("element width other than 32 was accepted");

    overlapRefused_a: assert property (
        state_reg == VAK_IDLE && start && isFinal && overlap |=> illegal)
        else $error("overlapping scalar form was accepted");

    finalAccept_a: assert property (
        state_reg == VAK_IDLE && start && isFinal && !bad && startGrp < endGrp
        |=> rdValid && rdGroup == $past(startGrp))
        else $error("legal final round did not start");

    groupRange_a: assert property (
        rdValid |-> rdGroup >= first_reg && rdGroup < end_reg)
        else $error("group read outside body");

    scalarKey_a: assert property (
        rdValid |-> keyGroup == (vv_reg ? rdGroup : '0))
        else $error("wrong key group selected");

    fixedLatency_a: assert property (
        rdValid |-> ##2 wrEn && wrGroup == $past(rdGroup, 2))
        else $error("write did not follow read by two cycles");

    round128_a: assert property (
        op_reg == VAK_KEY128 |-> roundEff >= 4'h1 && roundEff <= `VAK_R128_MAX)
        else $error("128 round out of range");

    round256_a: assert property (
        op_reg == VAK_KEY256 |-> roundEff >= `VAK_R256_MIN && roundEff <= `VAK_R256_MAX)
        else $error("256 round out of range");

    midRun_c: cover property (op_reg == VAK_MID && wrEn ##2 done);
    key256Run_c: cover property (op_reg == VAK_KEY256 && wrEn && !vv_reg);
    refused_c: cover property (illegal);
    emptyBody_c: cover property (state_reg == VAK_IDLE && start ##1 done && !busy);
endmodule // vak_core
`default_nettype wire

// >>> testbench/vak_vrf_model.sv
`timescale 1ns/1ps
`default_nettype none
// Register file stand-in: eight element groups of state and of key.
module vak_vrf_model #(
    parameter int VLW = 16
) (
    input wire logic mclk,
    input wire logic rdValid,
    input wire logic [VLW-3:0] rdGroup,
    input wire logic [VLW-3:0] keyGroup,
    input wire logic wrEn,
    input wire logic [VLW-3:0] wrGroup,
    input wire vak_pkg::vak_block_t wrData,
    output vak_pkg::vak_block_t stateData,
    output vak_pkg::vak_block_t keyData
);
    import vak_pkg::*;
    vak_block_t stMem [8]; // Destination groups, loaded by the bench.
    vak_block_t keyMem [8]; // Key source groups, loaded by the bench.
    initial begin
        stateData = '0;
        keyData = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data stand one cycle after a request; between reads they invert
    // every cycle, so a late capture in the core can never look right.
    always @(posedge mclk) begin
        if (rdValid) begin
            stateData <= stMem[rdGroup[2:0]];
            keyData <= keyMem[keyGroup[2:0]];
        end else begin
            stateData <= ~stateData;
            keyData <= ~keyData;
        end
    end
    // Writes land at once; only eight groups exist, so the index is cut.
    always @(posedge mclk) begin
        if (wrEn) begin
            stMem[wrGroup[2:0]] <= wrData;
        end
    end
endmodule // vak_vrf_model
`default_nettype wire

// >>> testbench/vector_aes_enc_keysched_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vector_aes_enc_keysched_tb_top;
    import vak_pkg::*;
    logic mclk, resetn, start, busy, rdValid, wrEn, done, illegal;
    logic [31:0] instr;
    logic [2:0] sew;
    logic [15:0] groupBits, vectorLength, startIndex;
    logic [3:0] groupRegs;
    logic [13:0] rdGroup, keyGroup, wrGroup;
    vak_block_t stateData, keyData, wrData;
    vak_block_t stArr [8]; // Bench copy of the destination groups.
    vak_block_t kyArr [8]; // Bench copy of the key groups.
    logic [7:0] sbt [256]; // Substitution table, built from field maths.
    int errors = 0;
    int cmp_count = 0;
    vak_core #(.VLW(16)) dut_u (.mclk(mclk), .resetn(resetn), .start(start),
        .instr(instr), .sew(sew), .groupBits(groupBits), .groupRegs(groupRegs),
        .vectorLength(vectorLength), .startIndex(startIndex),
        .stateData(stateData), .keyData(keyData), .busy(busy),
        .rdValid(rdValid), .rdGroup(rdGroup), .keyGroup(keyGroup), .wrEn(wrEn),
        .wrGroup(wrGroup), .wrData(wrData), .done(done), .illegal(illegal));
    vak_vrf_model #(.VLW(16)) mdl_u (.mclk(mclk), .rdValid(rdValid),
        .rdGroup(rdGroup), .keyGroup(keyGroup), .wrEn(wrEn), .wrGroup(wrGroup),
        .wrData(wrData), .stateData(stateData), .keyData(keyData));
    ////////////////////////////////////////////////////////////////////////
    // Reference arithmetic, kept apart from the core's own functions.
    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    endfunction
    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ a;
            a = xt(a);
        end
        return p;
    endfunction
    function automatic logic [31:0] subw(input logic [31:0] w);
        return {sbt[w[31:24]], sbt[w[23:16]], sbt[w[15:8]], sbt[w[7:0]]};
    endfunction
    // Round constant: repeated doubling gives 01 up to 80, then 1B, 36.
    function automatic logic [31:0] rc(input logic [3:0] i);
        logic [7:0] r;
        r = 8'h01;
        repeat (i) r = xt(r);
        return {24'h00_0000, r};
    endfunction
    function automatic logic [31:0] enc(input logic [5:0] f, input logic [4:0] v2,
        input logic [4:0] im, input logic [4:0] dst);
        return {f, 1'b1, v2, im, 3'h2, dst, 7'h77};
    endfunction
    // Expected group result; kind 0 final, 1 middle, 2 and 3 key steps.
    function automatic vak_block_t refr(input int kind, input logic [4:0] imm,
        input vak_block_t s, input vak_block_t k);
        vak_block_t t, src;
        logic [3:0] rn;
        logic [31:0] u, m;
        rn = imm[3:0];
        if (kind >= 2) begin
            if (kind == 2 && (rn > 4'hA || rn == 4'h0)) rn[3] = ~rn[3];
            if (kind == 3 && (rn < 4'h2 || rn > 4'hE)) rn[3] = ~rn[3];
            src = (kind == 2) ? k : s;
            u = {k[103:96], k[127:104]};
            if (kind == 2) t[31:0] = subw(u) ^ rc(rn - 4'h1);
            else if (rn[0]) t[31:0] = subw(k[127:96]);
            else t[31:0] = subw(u) ^ rc((rn >> 1) - 4'h1);
            t[31:0] = t[31:0] ^ src[31:0];
            for (int n = 1; n < 4; n++) t[32*n+:32] = t[32*(n-1)+:32] ^ src[32*n+:32];
            return t;
        end
        // Byte b sits in row b%4, column b/4; rows shift left by row number.
        for (int b = 0; b < 16; b++) t[8*b+:8] = sbt[s[8*((b/4+b%4)%4*4+b%4)+:8]];
        for (int c = 0; c < 4 && kind == 1; c++) begin
            u = t[32*c+:32];
            for (int r = 0; r < 4; r++) m[8*r+:8] = xt(u[8*r+:8]) ^ xt(u[8*((r+1)%4)+:8])
                ^ u[8*((r+1)%4)+:8] ^ u[8*((r+2)%4)+:8] ^ u[8*((r+3)%4)+:8];
            t[32*c+:32] = m;
        end
        return t ^ k;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic mk_sbox();
        logic [7:0] v;
        for (int x = 0; x < 256; x++) begin
            v = 8'h00;
            for (int y = 1; y < 256; y++) if (gm(x[7:0], y[7:0]) == 8'h01) v = y[7:0];
            sbt[x] = v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]}
                ^ {v[3:0], v[7:4]} ^ 8'h63;
        end
    endtask
    task automatic chk(input bit c, input string msg);
        cmp_count++;
        if (!c) begin
            errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // Fresh data per scenario, so latency is seen over varied values.
    task automatic fill(input int s);
        logic [31:0] h;
        for (int g = 0; g < 8; g++) begin
            h = 32'(s * (g + 1)) * 32'h9e37_79b9;
            stArr[g] = {h, h ^ 32'h5a5a_5a5a, ~h, h + 32'h0101_0101};
            kyArr[g] = {h + 32'h1234_5678, ~h ^ 32'h00ff_00ff, h, h ^ 32'hf0f0_0f0f};
            mdl_u.stMem[g] = stArr[g];
            mdl_u.keyMem[g] = kyArr[g];
        end
    endtask
    // Issue one instruction, follow it to retirement, then judge every group.
    task automatic run(input logic [31:0] ins, input logic [2:0] sw, input logic [15:0] gb,
        input logic [3:0] lm, input int len, input int vs, input int kind, input bit ok);
        int cyc, nw, lo, hi;
        vak_block_t e;
        lo = vs / 4;
        hi = (ok && len / 4 > lo) ? len / 4 : lo;
        @(posedge mclk);
        start <= 1'b1;
        instr <= ins;
        sew <= sw;
        groupBits <= gb;
        groupRegs <= lm;
        vectorLength <= 16'(len);
        startIndex <= 16'(vs);
        @(posedge mclk);
        start <= 1'b0;
        cyc = 0;
        nw = 0;
        while (cyc < 40) begin
            #1;
            cyc++;
            if (wrEn === 1'b1) begin
                chk(wrGroup === 14'(lo + nw), "group order");
                chk(busy === 1'b1, "busy while writing");
                nw++;
            end
            if (done === 1'b1 || illegal === 1'b1) break;
            @(posedge mclk);
        end
        chk(illegal === !ok && done === ok, "retire kind");
        // Done follows the last write by two cycles: the drain waits for
        // the write strobe itself to fall before retiring.
        chk(cyc == ((hi > lo) ? hi - lo + 4 : 1), "latency");
        chk(busy === 1'b0, "busy after retire");
        chk(nw == hi - lo, "write count");
        for (int g = 0; g < 8; g++) begin
            e = (g >= lo && g < hi) ? refr(kind, ins[19:15], stArr[g],
                kyArr[ins[26] ? 0 : g]) : stArr[g];
            chk(mdl_u.stMem[g] === e, "group data");
            stArr[g] = e;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_final();
        fill(1);
        run(enc(6'h28, 5'd8, 5'h03, 5'd0), 3'h2, 16'h0080, 4'h1, 15, 4, 0, 1);
        run(enc(6'h29, 5'd6, 5'h03, 5'd4), 3'h2, 16'h0100, 4'h2, 32, 0, 0, 1);
        $display("final round done");
    endtask
    task automatic t_mid();
        fill(2);
        run(enc(6'h28, 5'd8, 5'h02, 5'd0), 3'h2, 16'h0080, 4'h1, 12, 0, 1, 1);
        run(enc(6'h29, 5'd0, 5'h02, 5'd8), 3'h2, 16'h0400, 4'h8, 32, 20, 1, 1);
        run(enc(6'h28, 5'd8, 5'h02, 5'd0), 3'h2, 16'h0080, 4'h1, 8, 8, 1, 1);
        $display("middle round done");
    endtask
    // Every immediate, so folding, the ignored top bit and all constants show.
    task automatic t_keys();
        fill(3);
        for (int i = 0; i < 32; i++) begin
            run(enc(6'h22, 5'd2, 5'(i), 5'd9), 3'h2, 16'h0080, 4'h1, 8, 0, 2, 1);
            run(enc(6'h2A, 5'd2, 5'(i), 5'd9), 3'h2, 16'h0080, 4'h1, 8, 4, 3, 1);
        end
        $display("key steps done");
    endtask
    task automatic t_illegal();
        fill(4);
        run(enc(6'h28, 5'd8, 5'h03, 5'd0), 3'h3, 16'h0080, 4'h1, 16, 0, 0, 0);
        run(enc(6'h22, 5'd2, 5'h01, 5'd9), 3'h0, 16'h0080, 4'h1, 16, 0, 2, 0);
        run(enc(6'h2A, 5'd2, 5'h02, 5'd9), 3'h1, 16'h0080, 4'h1, 16, 0, 3, 0);
        run(enc(6'h29, 5'd5, 5'h02, 5'd4), 3'h2, 16'h0100, 4'h2, 16, 0, 1, 0);
        run(enc(6'h29, 5'd4, 5'h03, 5'd4), 3'h2, 16'h0080, 4'h1, 16, 0, 0, 0);
        run(enc(6'h28, 5'd8, 5'h02, 5'd0), 3'h2, 16'h0040, 4'h1, 16, 0, 1, 0);
        run(enc(6'h2A, 5'd8, 5'h02, 5'd0), 3'h2, 16'h007f, 4'h1, 16, 0, 3, 0);
        run(enc(6'h28, 5'd8, 5'h01, 5'd0), 3'h2, 16'h0080, 4'h1, 16, 0, 0, 0);
        $display("refusals done");
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // The clock runs at 10 MHz.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // The whole run needs well under two thousand cycles.
    initial begin
        #2_000_000;
        errors++;
        close_out();
    end
    initial begin
        resetn = 1'b0;
        start = 1'b0;
        instr = 32'h0000_0000;
        sew = 3'h2;
        groupBits = 16'h0080;
        groupRegs = 4'h1;
        vectorLength = 16'h0000;
        startIndex = 16'h0000;
        mk_sbox();
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_final();
        t_mid();
        t_keys();
        t_illegal();
        close_out();
    end
endmodule // vector_aes_enc_keysched_tb_top
`default_nettype wire
